// [src/swl_pkg.sv]
// Shared timing and command definitions for the single-wire link
package swl_pkg;

   typedef logic [15:0] swl_cnt_t;

   // Commands the host end accepts
   typedef enum logic [1:0] {
      SWL_RESET = 2'h0,
      SWL_WRITE0 = 2'h1,
      SWL_WRITE1 = 2'h2,
      SWL_READ = 2'h3
   } swl_cmd_e;

   // System clock period
   localparam int CLK_NS = 25;

   // Least time, rounded up to whole cycles
   function automatic swl_cnt_t up(input int ns);
      return swl_cnt_t'((ns + CLK_NS - 1) / CLK_NS);
   endfunction

   // Longest time, rounded down, never below one cycle
   function automatic swl_cnt_t dn(input int ns);
      return (ns < CLK_NS) ? 16'h0001 : swl_cnt_t'(ns / CLK_NS);
   endfunction

   // Speed-dependent selection
   function automatic swl_cnt_t pick(input logic od, input swl_cnt_t s,
                                     input swl_cnt_t o);
      return od ? o : s;
   endfunction

   // Device end times in ns
   localparam int DET_STD_NS = 120000;
   localparam int DET_OD_NS = 16000;
   localparam int RST_LONG_NS = 480000;
   localparam int KEEP_OD_NS = 80000;
   localparam int PDH_STD_NS = 30000;
   localparam int PDH_OD_NS = 3000;
   localparam int PDL_STD_NS = 120000;
   localparam int PDL_OD_NS = 12000;
   localparam int REC_STD_NS = 5000;
   localparam int REC_OD_NS = 2000;
   localparam int SMP_STD_NS = 30000;
   localparam int SMP_OD_NS = 4000;
   localparam int HOLD_STD_NS = 45000;
   localparam int HOLD_OD_NS = 6000;

   // Device end counts
   localparam swl_cnt_t DET_STD_CYC = up(DET_STD_NS);
   localparam swl_cnt_t DET_OD_CYC = up(DET_OD_NS);
   localparam swl_cnt_t RST_LONG_CYC = up(RST_LONG_NS);
   localparam swl_cnt_t KEEP_OD_CYC = dn(KEEP_OD_NS);
   localparam swl_cnt_t PDH_STD_CYC = up(PDH_STD_NS);
   localparam swl_cnt_t PDH_OD_CYC = up(PDH_OD_NS);
   localparam swl_cnt_t PDL_STD_CYC = up(PDL_STD_NS);
   localparam swl_cnt_t PDL_OD_CYC = up(PDL_OD_NS);
   localparam swl_cnt_t REC_STD_CYC = up(REC_STD_NS);
   localparam swl_cnt_t REC_OD_CYC = up(REC_OD_NS);
   localparam swl_cnt_t SMP_STD_CYC = up(SMP_STD_NS);
   localparam swl_cnt_t SMP_OD_CYC = up(SMP_OD_NS);
   localparam swl_cnt_t HOLD_STD_CYC = up(HOLD_STD_NS);
   localparam swl_cnt_t HOLD_OD_CYC = up(HOLD_OD_NS);

   // Host end times in ns
   localparam int RSTL_STD_NS = 480000;
   localparam int RSTL_OD_NS = 60000;
   localparam int RSTH_STD_NS = 480000;
   localparam int RSTH_OD_NS = 48000;
   localparam int MSP_STD_NS = 70000;
   localparam int MSP_OD_NS = 8000;
   localparam int W1L_STD_NS = 6000;
   localparam int W1L_OD_NS = 1000;
   localparam int W0L_STD_NS = 60000;
   localparam int W0L_OD_NS = 8000;
   localparam int RL_STD_NS = 6000;
   localparam int RL_OD_NS = 1000;
   localparam int MSR_STD_NS = 13000;
   localparam int MSR_OD_NS = 2000;
   localparam int SLOT_STD_NS = 70000;
   localparam int SLOT_OD_NS = 10000;

   // Host end counts
   localparam swl_cnt_t RSTL_STD_CYC = up(RSTL_STD_NS);
   localparam swl_cnt_t RSTL_OD_CYC = dn(RSTL_OD_NS);
   localparam swl_cnt_t RSTH_STD_CYC = up(RSTH_STD_NS);
   localparam swl_cnt_t RSTH_OD_CYC = up(RSTH_OD_NS);
   localparam swl_cnt_t MSP_STD_CYC = up(MSP_STD_NS);
   localparam swl_cnt_t MSP_OD_CYC = up(MSP_OD_NS);
   localparam swl_cnt_t W1L_STD_CYC = dn(W1L_STD_NS);
   localparam swl_cnt_t W1L_OD_CYC = dn(W1L_OD_NS);
   localparam swl_cnt_t W0L_STD_CYC = up(W0L_STD_NS);
   localparam swl_cnt_t W0L_OD_CYC = up(W0L_OD_NS);
   localparam swl_cnt_t RL_STD_CYC = up(RL_STD_NS);
   localparam swl_cnt_t RL_OD_CYC = up(RL_OD_NS);
   localparam swl_cnt_t MSR_STD_CYC = up(MSR_STD_NS);
   localparam swl_cnt_t MSR_OD_CYC = up(MSR_OD_NS);
   localparam swl_cnt_t SLOT_STD_CYC = up(SLOT_STD_NS);
   localparam swl_cnt_t SLOT_OD_CYC = up(SLOT_OD_NS);

endpackage

// [src/swl_link_if.sv]
// Open-drain single-wire line shared by the device and host ends
`timescale 1ns/1ps
`default_nettype none
interface swl_link_if;
   logic dev_do;
   logic dev_oe;
   logic host_do;
   logic host_oe;
   logic line;

   // Wired-AND with a pull-up: any enabled low driver wins
   assign line = ~((dev_oe & ~dev_do) | (host_oe & ~host_do));

   modport dev (input line, output dev_do, output dev_oe);
   modport host (input line, output host_do, output host_oe);
endinterface
`default_nettype wire

// [src/swl_dev_end.sv]
// Device end of the single-wire link: reset, presence and bit slots
`timescale 1ns/1ps
`default_nettype none
module swl_dev_end #(
   parameter swl_pkg::swl_cnt_t DET_STD_CYC = swl_pkg::DET_STD_CYC,
   parameter swl_pkg::swl_cnt_t RST_LONG_CYC = swl_pkg::RST_LONG_CYC,
   parameter swl_pkg::swl_cnt_t PDL_STD_CYC = swl_pkg::PDL_STD_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Line
   swl_link_if.dev link,
   // Bit stream and speed
   input wire logic tx_en,
   input wire logic tx_bit,
   input wire logic od_set,
   output logic rx_valid,
   output logic rx_bit,
   output logic reset_seen,
   output logic overdrive_flag
);

   typedef enum logic [2:0] {
      SWL_D_IDLE = 3'h0,
      SWL_D_LOW = 3'h1,
      SWL_D_WAITH = 3'h3,
      SWL_D_REC = 3'h2,
      SWL_D_PDH = 3'h6,
      SWL_D_PDL = 3'h7
   } swl_dstate_e;

   swl_dstate_e state, next_state;
   swl_pkg::swl_cnt_t cnt, next_cnt;
   swl_pkg::swl_cnt_t low_cnt, next_low_cnt;
   logic sync1, line_s, line_d;
   logic drive, next_drive;
   logic zero, next_zero;
   logic next_rx_valid, next_rx_bit, next_reset_seen, next_od;
   logic rise, fall, long_low;
   swl_pkg::swl_cnt_t det;

   // Two-stage synchroniser, then one delay for edges
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 1'b1;
         line_s <= 1'b1;
         line_d <= 1'b1;
      end else begin
         sync1 <= link.line;
         line_s <= sync1;
         line_d <= line_s;
      end
   end

   assign rise = line_s & ~line_d;
   assign fall = ~line_s & line_d;
   assign det = swl_pkg::pick(overdrive_flag, DET_STD_CYC,
                              swl_pkg::DET_OD_CYC);
   assign long_low = rise & (low_cnt >= det);

   // Only low driven from outside counts toward a reset
   always_comb begin
      if (line_s || drive) begin
         next_low_cnt = '0;
      end else if (low_cnt != 16'hFFFF) begin
         next_low_cnt = low_cnt + 16'h0001;
      end else begin
         next_low_cnt = low_cnt;
      end
   end

   // Slot, reset and presence sequencing
   always_comb begin
      next_state = state;
      next_cnt = cnt + 16'h0001;
      next_drive = drive;
      next_zero = zero;
      next_rx_valid = 1'b0;
      next_rx_bit = rx_bit;
      next_reset_seen = 1'b0;
      next_od = overdrive_flag;
      if (long_low) begin
         // Long reset drops speed; short one in fast mode keeps it
         next_od = overdrive_flag & (low_cnt <= swl_pkg::KEEP_OD_CYC)
            & (low_cnt < RST_LONG_CYC);
         next_reset_seen = 1'b1;
         next_drive = 1'b0;
         next_state = SWL_D_PDH;
         next_cnt = '0;
      end else begin
         unique case (state)
            SWL_D_IDLE: begin
               if (fall) begin
                  // Slot timer starts on the falling edge
                  next_state = SWL_D_LOW;
                  next_cnt = '0;
                  next_zero = tx_en & ~tx_bit;
                  next_drive = tx_en & ~tx_bit;
               end
            end
            SWL_D_LOW: begin
               if (cnt == swl_pkg::pick(overdrive_flag,
                     swl_pkg::SMP_STD_CYC, swl_pkg::SMP_OD_CYC)) begin
                  // One bit per slot, sampled at the timer point
                  next_rx_valid = 1'b1;
                  next_rx_bit = line_s & ~zero;
               end
               if (cnt >= swl_pkg::pick(overdrive_flag,
                     swl_pkg::HOLD_STD_CYC, swl_pkg::HOLD_OD_CYC)) begin
                  next_drive = 1'b0;
                  next_state = SWL_D_WAITH;
               end
            end
            SWL_D_WAITH: begin
               if (line_s) begin
                  next_state = SWL_D_REC;
                  next_cnt = '0;
               end
            end
            SWL_D_REC: begin
               // Falling edges during recovery are not slots
               if (!line_s) begin
                  next_state = SWL_D_WAITH;
               end else if (cnt >= swl_pkg::pick(overdrive_flag,
                     swl_pkg::REC_STD_CYC, swl_pkg::REC_OD_CYC)) begin
                  next_state = SWL_D_IDLE;
               end
            end
            SWL_D_PDH: begin
               if (cnt >= swl_pkg::pick(overdrive_flag,
                     swl_pkg::PDH_STD_CYC, swl_pkg::PDH_OD_CYC)) begin
                  // Presence is the one low the device starts
                  next_drive = 1'b1;
                  next_state = SWL_D_PDL;
                  next_cnt = '0;
               end
            end
            SWL_D_PDL: begin
               if (cnt >= swl_pkg::pick(overdrive_flag, PDL_STD_CYC,
                     swl_pkg::PDL_OD_CYC)) begin
                  next_drive = 1'b0;
                  next_state = SWL_D_WAITH;
               end
            end
            default: begin
               next_state = SWL_D_IDLE;
               next_drive = 1'b0;
            end
         endcase
      end
      // Command layer request to go fast wins over a clear
      if (od_set) begin
         next_od = 1'b1;
      end
      if (cnt == 16'hFFFF) begin
         next_cnt = cnt;
      end
   end

   // State registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= SWL_D_IDLE;
         cnt <= '0;
         low_cnt <= '0;
         drive <= 1'b0;
         zero <= 1'b0;
         rx_valid <= 1'b0;
         rx_bit <= 1'b0;
         reset_seen <= 1'b0;
         overdrive_flag <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         low_cnt <= next_low_cnt;
         drive <= next_drive;
         zero <= next_zero;
         rx_valid <= next_rx_valid;
         rx_bit <= next_rx_bit;
         reset_seen <= next_reset_seen;
         overdrive_flag <= next_od;
      end
   end

   // Open drain: data always low, enable carries the drive
   assign link.dev_do = 1'b0;
   assign link.dev_oe = drive;

endmodule
`default_nettype wire

// [src/swl_host_end.sv]
// Host end of the single-wire link: drives resets and bit slots
`timescale 1ns/1ps
`default_nettype none
module swl_host_end #(
   parameter swl_pkg::swl_cnt_t RSTL_STD_CYC = swl_pkg::RSTL_STD_CYC,
   parameter swl_pkg::swl_cnt_t RSTH_STD_CYC = swl_pkg::RSTH_STD_CYC,
   parameter swl_pkg::swl_cnt_t FALL_CYC = 16'h0000
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Line
   swl_link_if.host link,
   // Command request
   input wire logic cmd_valid,
   input wire swl_pkg::swl_cmd_e cmd,
   input wire logic od_mode,
   output logic cmd_ready,
   // Result
   output logic done,
   output logic rd_bit,
   output logic presence
);

   typedef enum logic [1:0] {
      SWL_H_IDLE = 2'h0,
      SWL_H_LOW = 2'h1,
      SWL_H_REL = 2'h3
   } swl_hstate_e;

   swl_hstate_e state, next_state;
   swl_pkg::swl_cnt_t cnt, next_cnt;
   swl_pkg::swl_cnt_t low_len, next_low_len;
   swl_pkg::swl_cnt_t smp_at, next_smp_at;
   swl_pkg::swl_cnt_t end_at, next_end_at;
   logic is_rst, next_is_rst;
   logic drive, next_drive;
   logic next_cmd_ready, next_done, next_rd_bit, next_presence;
   logic sync1, line_s;

   // Two-stage synchroniser on the line
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 1'b1;
         line_s <= 1'b1;
      end else begin
         sync1 <= link.line;
         line_s <= sync1;
      end
   end

   // Command decode into low length, sample point and slot end
   always_comb begin
      next_state = state;
      next_cnt = cnt + 16'h0001;
      next_low_len = low_len;
      next_smp_at = smp_at;
      next_end_at = end_at;
      next_is_rst = is_rst;
      next_drive = drive;
      next_cmd_ready = cmd_ready;
      next_done = 1'b0;
      next_rd_bit = rd_bit;
      next_presence = presence;
      unique case (state)
         SWL_H_IDLE: begin
            if (cmd_valid && cmd_ready) begin
               // Every slot and reset opens with a host fall
               next_drive = 1'b1;
               next_cmd_ready = 1'b0;
               next_cnt = '0;
               next_state = SWL_H_LOW;
               next_is_rst = (cmd == swl_pkg::SWL_RESET);
               unique case (cmd)
                  swl_pkg::SWL_RESET: begin
                     // Extra low time covers a slowed fall edge
                     next_low_len = swl_pkg::swl_cnt_t'(FALL_CYC
                        + swl_pkg::pick(od_mode, RSTL_STD_CYC,
                          swl_pkg::RSTL_OD_CYC));
                     next_smp_at = swl_pkg::swl_cnt_t'(next_low_len
                        + swl_pkg::pick(od_mode, swl_pkg::MSP_STD_CYC,
                          swl_pkg::MSP_OD_CYC));
                     // High window long enough for mixed networks
                     next_end_at = swl_pkg::swl_cnt_t'(next_low_len
                        + swl_pkg::pick(od_mode, RSTH_STD_CYC,
                          swl_pkg::RSTH_OD_CYC));
                  end
                  swl_pkg::SWL_WRITE0: begin
                     next_low_len = swl_pkg::pick(od_mode,
                        swl_pkg::W0L_STD_CYC, swl_pkg::W0L_OD_CYC);
                     next_smp_at = swl_pkg::pick(od_mode,
                        swl_pkg::SLOT_STD_CYC, swl_pkg::SLOT_OD_CYC);
                     next_end_at = next_smp_at;
                  end
                  swl_pkg::SWL_WRITE1: begin
                     next_low_len = swl_pkg::pick(od_mode,
                        swl_pkg::W1L_STD_CYC, swl_pkg::W1L_OD_CYC);
                     next_smp_at = swl_pkg::pick(od_mode,
                        swl_pkg::SLOT_STD_CYC, swl_pkg::SLOT_OD_CYC);
                     next_end_at = next_smp_at;
                  end
                  swl_pkg::SWL_READ: begin
                     next_low_len = swl_pkg::pick(od_mode,
                        swl_pkg::RL_STD_CYC, swl_pkg::RL_OD_CYC);
                     next_smp_at = swl_pkg::pick(od_mode,
                        swl_pkg::MSR_STD_CYC, swl_pkg::MSR_OD_CYC);
                     next_end_at = swl_pkg::pick(od_mode,
                        swl_pkg::SLOT_STD_CYC, swl_pkg::SLOT_OD_CYC);
                  end
                  default: begin
                     next_low_len = low_len;
                  end
               endcase
            end
         end
         SWL_H_LOW: begin
            // Full drive low for the whole low window
            if (cnt >= low_len) begin
               next_drive = 1'b0;
               next_state = SWL_H_REL;
            end
         end
         SWL_H_REL: begin
            if (cnt == smp_at) begin
               // One bit per slot, or presence after reset
               if (is_rst) begin
                  next_presence = ~line_s;
               end else begin
                  next_rd_bit = line_s;
               end
            end
            // Full slot wait gives the device its recovery
            if (cnt >= end_at) begin
               next_done = 1'b1;
               next_cmd_ready = 1'b1;
               next_state = SWL_H_IDLE;
            end
         end
         default: begin
            next_state = SWL_H_IDLE;
            next_drive = 1'b0;
            next_cmd_ready = 1'b1;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= SWL_H_IDLE;
         cnt <= '0;
         low_len <= '0;
         smp_at <= '0;
         end_at <= '0;
         is_rst <= 1'b0;
         drive <= 1'b0;
         cmd_ready <= 1'b1;
         done <= 1'b0;
         rd_bit <= 1'b0;
         presence <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         low_len <= next_low_len;
         smp_at <= next_smp_at;
         end_at <= next_end_at;
         is_rst <= next_is_rst;
         drive <= next_drive;
         cmd_ready <= next_cmd_ready;
         done <= next_done;
         rd_bit <= next_rd_bit;
         presence <= next_presence;
      end
   end

   // Open drain: data always low, enable carries the drive
   assign link.host_do = 1'b0;
   assign link.host_oe = drive;

endmodule
`default_nettype wire

// [verification/swl_link_assertions.sv]
// Wire-level checks on the single-wire link between the two ends
`timescale 1ns/1ps
`default_nettype none
module swl_link_assertions (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Line signals
   input wire logic dev_do,
   input wire logic dev_oe,
   input wire logic host_do,
   input wire logic host_oe,
   input wire logic line
);
   logic [15:0] dev_run;
   logic [15:0] host_run;
   logic [15:0] hi_run;

   // Run lengths of each pull-down and of the released line
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dev_run <= 16'h0000;
         host_run <= 16'h0000;
         hi_run <= 16'hFFFF;
      end else begin
         dev_run <= dev_oe ? dev_run + 16'h0001 : 16'h0000;
         host_run <= host_oe ? host_run + 16'h0001 : 16'h0000;
         hi_run <= !line ? 16'h0000 :
                   (hi_run == 16'hFFFF) ? hi_run : hi_run + 16'h0001;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_host_data_low: assert property (host_do == 1'b0)
      else $error("host drives the line high");
   a_dev_data_low: assert property (dev_do == 1'b0)
      else $error("device drives the line high");
   a_dev_pull_min: assert property (
      $fell(dev_oe) |-> dev_run >= 16'h00C8)
      else $error("device pull-down too short");
   a_dev_pull_max: assert property (dev_run <= 16'h12C2)
      else $error("device pull-down too long");
   a_read_answer: assert property (
      $rose(dev_oe) && host_oe |-> host_run <= 16'h0008)
      else $error("zero reply starts late");
   a_presence_gap: assert property (
      $rose(dev_oe) && !host_oe |-> hi_run >= 16'h0064)
      else $error("presence without delay");
   a_host_pull_min: assert property (
      $fell(host_oe) |-> host_run >= 16'h0028)
      else $error("host low pulse too short");
   a_slot_gap: assert property (
      $rose(host_oe) |-> hi_run >= 16'h003C)
      else $error("slot starts inside recovery");
   a_reset_quiet: assert property (
      $fell(host_oe) && host_run >= 16'h0960 |-> !dev_oe [*8])
      else $error("presence starts at reset release");

   // Main scenarios seen on the wire
   c_presence: cover property ($rose(dev_oe) && !host_oe);
   c_read_zero: cover property ($rose(dev_oe) && host_oe);
   c_fast_slot: cover property ($fell(host_oe) && host_run < 16'h0064);
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench joining the host and device ends of the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock, rst_n, tx_en, tx_bit, od_set, rx_valid, rx_bit;
   logic reset_seen, overdrive_flag, cmd_valid, od_mode, cmd_ready;
   logic done, rd_bit, presence, b;
   swl_pkg::swl_cmd_e cmd;
   int error_cnt, checked, seed, rs_cnt, model_od, r, i;
   logic q[$];

   swl_link_if swl_link_if_i();

   // Short reset detect, still above the standard write-zero low
   swl_dev_end #(.DET_STD_CYC(16'h0BB8), .RST_LONG_CYC(16'h0D48),
      .PDL_STD_CYC(swl_pkg::PDL_STD_CYC)) swl_dev_end_i (
      .clock(clock), .rst_n(rst_n), .link(swl_link_if_i),
      .tx_en(tx_en), .tx_bit(tx_bit), .od_set(od_set),
      .rx_valid(rx_valid), .rx_bit(rx_bit), .reset_seen(reset_seen),
      .overdrive_flag(overdrive_flag));

   swl_host_end #(.RSTL_STD_CYC(16'h0E10), .RSTH_STD_CYC(16'h1900),
      .FALL_CYC(16'h0010)) swl_host_end_i (
      .clock(clock), .rst_n(rst_n), .link(swl_link_if_i),
      .cmd_valid(cmd_valid), .cmd(cmd), .od_mode(od_mode),
      .cmd_ready(cmd_ready), .done(done), .rd_bit(rd_bit),
      .presence(presence));

   swl_link_assertions swl_link_assertions_i (
      .clock(clock), .rst_n(rst_n), .dev_do(swl_link_if_i.dev_do),
      .dev_oe(swl_link_if_i.dev_oe), .host_do(swl_link_if_i.host_do),
      .host_oe(swl_link_if_i.host_oe), .line(swl_link_if_i.line));

   // Clock at 40 MHz
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Single-bit comparison
   task automatic chk(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   // One host command, waiting for its done pulse
   task automatic run(input swl_pkg::swl_cmd_e c, input logic od);
      int n;
      n = 0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd <= c;
      od_mode <= od;
      @(posedge clock);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (done !== 1'b1 && n < 30000);
      if (n >= 30000) begin
         error_cnt++;
         report_and_stop();
      end
   endtask

   // Reset sequence with presence and speed check
   task automatic rst_cmd(input logic od);
      int n0;
      n0 = rs_cnt;
      // Reset low reaches the device sample point as a zero
      q.push_back(1'b0);
      run(swl_pkg::SWL_RESET, od);
      chk("presence", 1'b1, presence);
      chk("reset_seen", 1'b1, logic'(rs_cnt == n0 + 1));
      chk("overdrive_flag", logic'(model_od), overdrive_flag);
   endtask

   // One written bit then one read bit
   task automatic wr_rd(input logic od);
      r = $random(seed);
      b = r[0];
      q.push_back(b);
      run(b ? swl_pkg::SWL_WRITE1 : swl_pkg::SWL_WRITE0, od);
      r = $random(seed);
      b = r[0];
      q.push_back(b);
      @(posedge clock);
      tx_bit <= b;
      tx_en <= 1'b1;
      run(swl_pkg::SWL_READ, od);
      chk("rd_bit", b, rd_bit);
      @(posedge clock);
      tx_en <= 1'b0;
   endtask

   // Device-side results against the queued model
   always @(posedge clock) begin
      if (rst_n && rx_valid === 1'b1) begin
         if (q.size() == 0) begin
            chk("rx_valid", 1'b0, rx_valid);
         end else begin
            chk("rx_bit", q.pop_front(), rx_bit);
         end
      end
      if (rst_n && reset_seen === 1'b1) begin
         rs_cnt++;
      end
   end

   // Main sequence
   initial begin
      seed = 32'hCDAB;
      rst_n = 1'b0;
      {tx_en, tx_bit, od_set, cmd_valid, od_mode} = 5'h00;
      cmd = swl_pkg::SWL_RESET;
      model_od = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      chk("cmd_ready", 1'b1, cmd_ready);
      rst_cmd(1'b0);
      for (i = 0; i < 4; i++) begin
         wr_rd(1'b0);
      end
      @(posedge clock);
      od_set <= 1'b1;
      @(posedge clock);
      od_set <= 1'b0;
      model_od = 1;
      #1;
      chk("overdrive_flag", 1'b1, overdrive_flag);
      rst_cmd(1'b1);
      for (i = 0; i < 8; i++) begin
         wr_rd(1'b1);
      end
      model_od = 0;
      rst_cmd(1'b0);
      wr_rd(1'b0);
      repeat (4) @(posedge clock);
      chk("rx_left", 1'b1, logic'(q.size() == 0));
      report_and_stop();
   end
endmodule
`default_nettype wire
